// >>> design/mii_cycle_timer.v
`timescale 1ns/100ps
`include "mii_defs.vh"
module mii_cycle_timer #(
    parameter CYCLES = `MII_LOOKUP_CYC
) (
    input wire clk_sys,
    input wire resetn,
    input wire start,
    output wire done
);
    reg [23:0] count;
    reg running;
    assign done = running && (count == 24'h000001);
    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            count <= 24'h000000;
            running <= 1'b0;
        end
        else if (start)
        begin
            count <= CYCLES[23:0];
            running <= 1'b1;
        end
        else if (running)
        begin
            count <= count - 24'h000001;
            if (count == 24'h000001)
                running <= 1'b0;
        end
    end
endmodule // mii_cycle_timer

// >>> design/mii_defs.vh
`ifndef MII_DEFS_VH
`define MII_DEFS_VH
// Lookup pause in milliseconds and derived cycle count at 100 MHz
`define MII_LOOKUP_MS 150
`define MII_CLK_HZ 100000000
`define MII_LOOKUP_CYC (`MII_LOOKUP_MS * (`MII_CLK_HZ / 1000))
// Address length in digits
`define MII_DIGITS 5
`define MII_CNT_W 3
// Count value of the last address digit
`define MII_LAST_IDX 3'h4
// Format select reset value
`define MII_FMT_RST 2'h0
`endif

// >>> design/mii_manual_inquiry.v
// Operation
// - Without the hold plug the program runs undisturbed until all five address digits are keyed.
// - Each keyed address digit is echoed to the typewriter as it is entered.
// - After a full address without the plug, processing pauses about 150 ms plus file access time.
// - Three basic reply formats are selectable with the plug in; more are derived from buffer control characters.
// - With the plug in, the lamp lights only at the program inquiry point and keying waits for it.
// - Once the lamp is lit, processing halts while the address is keyed and the record located.
// - With the plug in, an unfinished address keeps the halt forever with no timeout.
// - With the plug in, inquiry keying and programmed print-out never share the typewriter.
// - An instruction touching the typewriter buffer is held while the typewriter is busy.
`timescale 1ns/100ps
`include "mii_defs.vh"
module mii_manual_inquiry #(
    parameter LOOKUP_CYC = `MII_LOOKUP_CYC
) (
    input wire clk_sys,
    input wire resetn,
    input wire inquiry_hold_plug,
    input wire [2:0] formatKey,
    input wire digitStrobe,
    input wire [3:0] digitValue,
    input wire atInquiryPoint,
    input wire bufferRef,
    input wire progPrintReq,
    input wire typewriterBusy,
    input wire recordFound,
    input wire replyStarted,
    input wire [1:0] ctrlChar,
    output reg programHalt,
    output reg inquiryLamp,
    output reg echoStrobe,
    output reg [3:0] echoDigit,
    output reg [19:0] fileAddr,
    output reg seekReq,
    output reg [1:0] replyFormat,
    output reg [1:0] formatVariant,
    output reg progPrintGrant
);
    localparam S_IDLE = 6'h01;
    localparam S_WAIT = 6'h02;
    localparam S_KEY = 6'h04;
    localparam S_PAUSE = 6'h08;
    localparam S_SEEK = 6'h10;
    localparam S_REPLY = 6'h20;

    // Two-stage synchronisers, one per operator pin
    localparam SYNC_W = 9;
    wire [SYNC_W-1:0] pinRaw = {inquiry_hold_plug, formatKey, digitStrobe, digitValue};
    wire [SYNC_W-1:0] pinSync;
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi = gi + 1)
        begin : gSync
            reg stageA;
            reg stageB;
            always @(posedge clk_sys or negedge resetn)
            begin
                if (!resetn)
                begin
                    stageA <= 1'b0;
                    stageB <= 1'b0;
                end
                else
                begin
                    stageA <= pinRaw[gi];
                    stageB <= stageA;
                end
            end
            assign pinSync[gi] = stageB;
        end
    endgenerate

    // Edge detector on the synchronised digit strobe
    reg strobeLast;
    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            strobeLast <= 1'b0;
        else
            strobeLast <= pinSync[4];
    end
    wire plug = pinSync[8];
    wire [2:0] keys = pinSync[7:5];
    wire digitEdge = pinSync[4] && !strobeLast;
    wire [3:0] digit = pinSync[3:0];

    reg [5:0] state;
    reg [5:0] next_state;
    reg [2:0] digitCount;
    reg plugMode;
    wire timerStart;
    wire timerDone;
    wire lastDigit = digitEdge && (digitCount == `MII_LAST_IDX);
    // Live plug level while idle, latched mode once an inquiry starts
    wire modeNow = (state == S_IDLE) ? plug : plugMode;

    mii_cycle_timer #(
        .CYCLES(LOOKUP_CYC)
    ) uTimer (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .start(timerStart),
        .done(timerDone)
    );
    assign timerStart = (state == S_KEY) && lastDigit && !plugMode;

    always @*
    begin
        next_state = state;
        case (state)
            S_IDLE:
            begin
                if (plug && (keys != 3'h0))
                    next_state = S_WAIT;
                else if (!plug && digitEdge)
                    next_state = S_KEY;
            end
            S_WAIT:
            begin
                if (atInquiryPoint && !typewriterBusy)
                    next_state = S_KEY;
            end
            S_KEY:
            begin
                if (lastDigit)
                    next_state = plugMode ? S_SEEK : S_PAUSE;
            end
            S_PAUSE:
            begin
                if (timerDone)
                    next_state = S_SEEK;
            end
            S_SEEK:
            begin
                if (recordFound)
                    next_state = S_REPLY;
            end
            S_REPLY:
            begin
                if (replyStarted)
                    next_state = S_IDLE;
            end
            default:
                next_state = S_IDLE;
        endcase
    end

    // Next values of the interlock outputs
    reg next_seek;
    reg next_lamp;
    reg next_halt;
    reg next_grant;
    always @*
    begin
        next_seek = (next_state == S_SEEK);
        next_lamp = modeNow && (next_state == S_KEY);
        next_halt = next_lamp || (next_state == S_PAUSE) || next_seek || (next_state == S_REPLY);
        if (bufferRef && typewriterBusy)
            next_halt = 1'b1;
        next_grant = progPrintReq && !typewriterBusy;
        if (next_state != S_IDLE && next_state != S_WAIT)
            next_grant = 1'b0;
    end

    always @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= S_IDLE;
            digitCount <= 3'h0;
            plugMode <= 1'b0;
            programHalt <= 1'b0;
            inquiryLamp <= 1'b0;
            echoStrobe <= 1'b0;
            echoDigit <= 4'h0;
            fileAddr <= 20'h00000;
            seekReq <= 1'b0;
            replyFormat <= `MII_FMT_RST;
            formatVariant <= 2'h0;
            progPrintGrant <= 1'b0;
        end
        else
        begin
            state <= next_state;
            echoStrobe <= 1'b0;
            if (state == S_IDLE)
            begin
                plugMode <= plug;
                digitCount <= 3'h0;
                if (plug && keys[0])
                    replyFormat <= 2'h0;
                else if (plug && keys[1])
                    replyFormat <= 2'h1;
                else if (plug && keys[2])
                    replyFormat <= 2'h2;
            end
            formatVariant <= ctrlChar;
            if ((state == S_KEY || (state == S_IDLE && !plug)) && digitEdge)
            begin
                echoStrobe <= 1'b1;
                echoDigit <= digit;
                fileAddr <= {fileAddr[15:0], digit};
                digitCount <= digitCount + 3'h1;
            end
            seekReq <= next_seek;
            inquiryLamp <= next_lamp;
            programHalt <= next_halt;
            progPrintGrant <= next_grant;
        end
    end
endmodule // mii_manual_inquiry

// >>> testbench/mii_check_assertions.sv
`timescale 1ns/100ps
module mii_check_assertions (
    input wire logic clk_sys, resetn, inquiry_hold_plug, bufferRef, typewriterBusy, progPrintGrant,
    input wire logic programHalt, inquiryLamp, echoStrobe, seekReq, atInquiryPoint,
    input wire logic [1:0] ctrlChar, replyFormat, formatVariant
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence bufBusy;
        (bufferRef && typewriterBusy) ##1 (bufferRef && typewriterBusy);
    endsequence
    echo_pulse_a: assert property (echoStrobe |=> !echoStrobe) else $error("long echo");
    lamp_halt_a: assert property (inquiryLamp |-> programHalt) else $error("lamp no halt");
    print_excl_a: assert property (progPrintGrant |-> !inquiryLamp) else $error("shared typer");
    buffer_hold_a: assert property (bufBusy |-> programHalt) else $error("buffer run");
    seek_halt_a: assert property (seekReq |-> programHalt) else $error("seek no halt");
    format_range_a: assert property (replyFormat != 2'h3) else $error("bad format");
    variant_delay_a: assert property ($past(resetn) |-> formatVariant == $past(ctrlChar))
        else $error("variant");
    lamp_point_a: assert property ($rose(inquiryLamp) |-> $past(atInquiryPoint)) else $error("lamp early");
    echo_held_a: assert property (echoStrobe && inquiry_hold_plug |-> programHalt) else $error("echo run");
endmodule // mii_check_assertions
bind mii_manual_inquiry mii_check_assertions chk_u (.*);

// >>> testbench/mii_manual_inquiry_tb.sv
`timescale 1ns/100ps
module mii_manual_inquiry_tb;
    logic clk_sys = 0, resetn = 0, inquiry_hold_plug = 0, atInquiryPoint = 0, bufferRef = 0, progPrintReq = 0;
    logic typewriterBusy = 0, recordFound = 0, replyStarted = 0, digitStrobe, programHalt, inquiryLamp;
    logic echoStrobe, seekReq, progPrintGrant;
    logic [1:0] ctrlChar = 2'h0, replyFormat, formatVariant;
    logic [2:0] formatKey;
    logic [3:0] digitValue, echoDigit;
    logic [19:0] fileAddr;
    int n_mismatch = 0, cmp_count = 0, echoCnt = 0, echoBase = 0;
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) echoCnt <= echoCnt + (echoStrobe === 1'h1);
    mii_operator op_u (
        .clk_sys(clk_sys),
        .formatKey(formatKey),
        .digitStrobe(digitStrobe),
        .digitValue(digitValue)
    );
    mii_manual_inquiry #(.LOOKUP_CYC(20)) dut_u (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .inquiry_hold_plug(inquiry_hold_plug),
        .formatKey(formatKey),
        .digitStrobe(digitStrobe),
        .digitValue(digitValue),
        .atInquiryPoint(atInquiryPoint),
        .bufferRef(bufferRef),
        .progPrintReq(progPrintReq),
        .typewriterBusy(typewriterBusy),
        .recordFound(recordFound),
        .replyStarted(replyStarted),
        .ctrlChar(ctrlChar),
        .programHalt(programHalt),
        .inquiryLamp(inquiryLamp),
        .echoStrobe(echoStrobe),
        .echoDigit(echoDigit),
        .fileAddr(fileAddr),
        .seekReq(seekReq),
        .replyFormat(replyFormat),
        .formatVariant(formatVariant),
        .progPrintGrant(progPrintGrant)
    );
    task chk(input logic [19:0] seen, exp);
        cmp_count++;
        n_mismatch += (seen !== exp);
        if (seen !== exp)
            $display("wrong value at %0t: %h vs %h", $time, seen, exp);
    endtask
    task keyAddr(input int n, input logic [19:0] a);
        for (int i = 0; i < n; i++)
            op_u.keyDigit(a[19 - 4 * i -: 4]);
    endtask
    task finishSeek;
        repeat (60) if (seekReq !== 1'h1) @(negedge clk_sys);
        chk(seekReq, 1);
        {recordFound, replyStarted} = 2'h3;
        repeat (9) if (programHalt !== 1'h0) @(negedge clk_sys);
        chk(programHalt, 0);
        {recordFound, replyStarted} = 2'h0;
    endtask
    task testUnplug;
        keyAddr(4, 20'h12345);
        chk(programHalt, 0);
        op_u.keyDigit(4'h5);
        chk(seekReq, 0);
        chk(programHalt, 1);
        chk(fileAddr, 20'h12345);
        chk(echoCnt, 5);
        chk(echoDigit, 4'h5);
        finishSeek;
        $display("unplug done");
    endtask
    task testPlug;
        inquiry_hold_plug = 1;
        echoBase = echoCnt;
        keyAddr(2, 20'h90000);
        chk(echoCnt - echoBase, 0);
        chk(echoDigit, 4'h5);
        op_u.pressKey(3'h2);
        chk(inquiryLamp, 0);
        atInquiryPoint = 1;
        repeat (20) if (inquiryLamp !== 1'h1) @(negedge clk_sys);
        chk(inquiryLamp, 1);
        chk(programHalt, 1);
        progPrintReq = 1;
        keyAddr(4, 20'h67890);
        repeat (200) @(negedge clk_sys);
        chk(progPrintGrant, 0);
        chk(programHalt, 1);
        op_u.keyDigit(4'h0);
        chk(fileAddr, 20'h67890);
        chk(echoDigit, 4'h0);
        chk(replyFormat, 1);
        finishSeek;
        $display("plug done");
    endtask
    task testBuffer;
        repeat (5) @(negedge clk_sys);
        chk(progPrintGrant, 1);
        {bufferRef, typewriterBusy, ctrlChar} = 4'hE;
        repeat (3) @(negedge clk_sys);
        chk(programHalt, 1);
        chk(formatVariant, 2'h2);
        chk(progPrintGrant, 0);
        typewriterBusy = 0;
        repeat (3) @(negedge clk_sys);
        chk(programHalt, 0);
        $display("buffer done");
    endtask
    task final_report;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(negedge clk_sys);
        resetn = 1;
        repeat (4) @(negedge clk_sys);
        testUnplug;
        testPlug;
        testBuffer;
        final_report;
    end
    initial
    begin
        #60000;
        n_mismatch++;
        final_report;
    end
endmodule // mii_manual_inquiry_tb

// >>> testbench/mii_operator.sv
`timescale 1ns/100ps
module mii_operator (
    input wire logic clk_sys,
    output logic [2:0] formatKey = 3'h0,
    output logic digitStrobe = 1'h0,
    output logic [3:0] digitValue = 4'h0
);
    task pressKey(input logic [2:0] k);
        formatKey = k;
        repeat (6) @(negedge clk_sys);
        formatKey = 3'h0;
    endtask
    task keyDigit(input logic [3:0] d);
        {digitStrobe, digitValue} = {1'h1, d};
        repeat (6) @(negedge clk_sys);
        {digitStrobe, digitValue} = {1'h0, ~d};
        repeat (6) @(negedge clk_sys);
    endtask
endmodule // mii_operator
